// ===== src/hsc_pkg.sv
// Shared constants and types of the dual counter block
package hsc_pkg;
	localparam int NPORT = 2;
	localparam int NENT = 8;
	localparam int NDIG = 8;
	localparam int CLK_MHZ = 100;
	localparam int SCAN_US = 10;
	localparam int SCAN_CYC = CLK_MHZ * SCAN_US;
	// Byte offsets on the register bus
	localparam logic [7:0] OFF_P1_LO = 8'h00;
	localparam logic [7:0] OFF_P1_HI = 8'h04;
	localparam logic [7:0] OFF_P2_LO = 8'h08;
	localparam logic [7:0] OFF_P2_HI = 8'h0C;
	localparam logic [7:0] OFF_RST = 8'h10;
	localparam logic [7:0] OFF_FLG1 = 8'h14;
	localparam logic [7:0] OFF_FLG2 = 8'h18;
	localparam logic [7:0] OFF_SET1 = 8'h1C;
	localparam logic [7:0] OFF_SET2 = 8'h20;
	localparam logic [7:0] OFF_CMD = 8'h24;
	localparam logic [7:0] OFF_NEWPV = 8'h28;
	localparam logic [7:0] OFF_ISTAT = 8'h2C;
	localparam logic [7:0] OFF_IMASK = 8'h30;
	localparam logic [7:0] OFF_GMASK = 8'h34;
	localparam logic [7:0] OFF_TLO = 8'h40;
	localparam logic [7:0] OFF_THI = 8'h60;
	// Field positions and values
	localparam int RST_LSB = 1;
	localparam int FLG_RUN = 8;
	localparam int FLG_OVF = 9;
	localparam int CMD_PORT = 8;
	localparam int ST_W = 3;
	localparam logic [3:0] IN_QUAD = 4'h0;
	localparam logic [3:0] IN_PDIR = 4'h1;
	localparam logic [3:0] IN_UPDN = 4'h2;
	localparam logic [3:0] RM_ZSW = 4'h0;
	localparam logic [3:0] RM_SW = 4'h1;
	localparam logic [3:0] NR_RING = 4'h1;
	localparam logic [31:0] BCD_MAX = 32'h9999_9999;
	typedef enum logic [3:0] {
		OP_NONE = 4'h0, OP_LDR_GO = 4'h1, OP_LDT_GO = 4'h2, OP_LDR = 4'h3,
		OP_LDT = 4'h4, OP_START = 4'h5, OP_STOP = 4'h6, OP_PVSET = 4'h7,
		OP_MASK = 4'h8, OP_UNMASK = 4'h9
	} op_t;
	// Port setup word: input mode, reset method, numeric range
	typedef struct packed {
		logic [3:0] spare;
		logic [3:0] range;
		logic [3:0] rmeth;
		logic [3:0] mode;
	} setup_t;
	typedef struct packed {
		logic z;
		logic b;
		logic a;
	} enc_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
endpackage

// ===== src/hsc_top.sv
// Two-port BCD pulse counter with compare tables and APB registers
//
// The APB register port and the register addresses were decided locally.
`timescale 1ns/1ns
// Summary of operation
// - Each port's count is published as 8-digit BCD once per scan tick.
// - Published count splits into low four digits word and high four digits word.
// - Phase-Z plus software method: Z pulse clears only while reset bit is 1.
// - Software-only method: reset bit rising 0 to 1 clears the count.
// - Flags 0..7 show table entries matched while range comparison runs.
// - Flag bit 8 shows comparison running.
// - Flag bit 9 shows overflow or underflow has occurred.
// - Port two has its own flag word, same layout.
// - Load range table and start comparing at once.
// - Load target table and start comparing at once.
// - Tables can be loaded without starting comparison.
// - Start and stop commands compare against the loaded table or halt.
// - A command overwrites a port's count with a supplied value.
// - Count, status and range result are readable.
// - Global mask suppresses all interrupts; unmask command removes it.
// - Input mode: 0 quadrature, 1 pulse plus direction, 2 up/down pulses.
// - Reset method: 0 phase Z plus software, 1 software only.
// - Numeric range: 0 linear, 1 ring with wraparound.
module hsc_top
	import hsc_pkg::*;
#(
	parameter int SCAN_CYCLES = SCAN_CYC
)(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// APB slave
	input wire apb_req_t i_apb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Encoder pins per port
	input wire enc_t [NPORT-1:0] i_enc,
	// Interrupt
	output logic o_irq
);
	typedef struct packed {
		enc_t s1;
		enc_t s2;
		enc_t old;
		logic swp;
		logic [31:0] cnt;
		logic [31:0] pub;
		logic run;
		logic is_rng;
		logic ovf;
		logic [NENT-1:0] hit;
		setup_t setup;
		logic [NENT-1:0][31:0] lo;
		logic [NENT-1:0][31:0] hi;
	} port_t;
	typedef struct packed {
		port_t [NPORT-1:0] pt;
		logic [NENT-1:0][31:0] sh_lo;
		logic [NENT-1:0][31:0] sh_hi;
		logic [15:0] rst;
		logic [31:0] newpv;
		logic [2*ST_W-1:0] istat;
		logic [2*ST_W-1:0] imask;
		logic gmask;
		logic [15:0] div;
		logic tick;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic irq;
	} state_t;

	state_t st;
	state_t next_st;

	// One decimal step up or down, digit by digit with carry
	function automatic logic [31:0] bcd_step(input logic [31:0] v, input logic up);
		logic [31:0] r;
		logic c;
		r = v;
		c = 1'b1;
		for (int d = 0; d < NDIG; d++)
		begin
			if (c && up)
			begin
				c = (v[d*4+:4] == 4'h9);
				r[d*4+:4] = c ? 4'h0 : v[d*4+:4] + 4'h1;
			end
			else if (c)
			begin
				c = (v[d*4+:4] == 4'h0);
				r[d*4+:4] = c ? 4'h9 : v[d*4+:4] - 4'h1;
			end
		end
		return r;
	endfunction

	// Bus phase decode
	logic acc;
	logic done;
	logic [31:0] rmux;
	logic rbad;
	logic [2*ST_W-1:0] ev;
	assign acc = i_apb.psel && i_apb.penable && !st.pready;
	assign done = i_apb.psel && i_apb.penable && st.pready;

	// Read mux; bits above a register's width read as zero
	always_comb
	begin
		rmux = 32'h0;
		rbad = 1'b0;
		case (i_apb.paddr)
			OFF_P1_LO: rmux = {16'h0, st.pt[0].pub[15:0]};
			OFF_P1_HI: rmux = {16'h0, st.pt[0].pub[31:16]};
			OFF_P2_LO: rmux = {16'h0, st.pt[1].pub[15:0]};
			OFF_P2_HI: rmux = {16'h0, st.pt[1].pub[31:16]};
			OFF_RST: rmux = {16'h0, st.rst};
			OFF_FLG1: rmux = {22'h0, st.pt[0].ovf, st.pt[0].run, st.pt[0].hit};
			OFF_FLG2: rmux = {22'h0, st.pt[1].ovf, st.pt[1].run, st.pt[1].hit};
			OFF_SET1: rmux = {16'h0, st.pt[0].setup};
			OFF_SET2: rmux = {16'h0, st.pt[1].setup};
			OFF_CMD: rmux = 32'h0;
			OFF_NEWPV: rmux = st.newpv;
			OFF_ISTAT: rmux = {26'h0, st.istat};
			OFF_IMASK: rmux = {26'h0, st.imask};
			OFF_GMASK: rmux = {31'h0, st.gmask};
			default:
			begin
				if (i_apb.paddr[7:5] == OFF_TLO[7:5] && i_apb.paddr[1:0] == 2'b00)
					rmux = st.sh_lo[i_apb.paddr[4:2]];
				else if (i_apb.paddr[7:5] == OFF_THI[7:5] && i_apb.paddr[1:0] == 2'b00)
					rmux = st.sh_hi[i_apb.paddr[4:2]];
				else
					rbad = 1'b1;
			end
		endcase
	end

	// Whole next state: bus, commands, counting, comparison, interrupts
	always_comb
	begin
		logic wr;
		logic up;
		logic step;
		logic clr;
		logic zed;
		logic rb;
		logic hitt;
		logic [NENT-1:0] nh;
		op_t op;
		logic pp;
		next_st = st;
		wr = done && i_apb.pwrite;
		op = op_t'(i_apb.pwdata[3:0]);
		pp = i_apb.pwdata[CMD_PORT];
		ev = '0;
		up = 1'b0;
		step = 1'b0;
		clr = 1'b0;
		zed = 1'b0;
		rb = 1'b0;
		hitt = 1'b0;
		nh = '0;
		// Scan divider; one enable pulse per scan period
		next_st.tick = (st.div == 16'(SCAN_CYCLES - 1));
		next_st.div = next_st.tick ? 16'h0 : st.div + 16'h1;
		// Register writes land on the completing edge only
		if (wr)
		begin
			case (i_apb.paddr)
				OFF_RST: next_st.rst[RST_LSB+:NPORT] = i_apb.pwdata[RST_LSB+:NPORT];
				OFF_SET1: next_st.pt[0].setup = setup_t'(i_apb.pwdata[15:0]);
				OFF_SET2: next_st.pt[1].setup = setup_t'(i_apb.pwdata[15:0]);
				OFF_NEWPV: next_st.newpv = i_apb.pwdata;
				OFF_IMASK: next_st.imask = i_apb.pwdata[2*ST_W-1:0];
				default:
				begin
					if (i_apb.paddr[7:5] == OFF_TLO[7:5] && i_apb.paddr[1:0] == 2'b00)
						next_st.sh_lo[i_apb.paddr[4:2]] = i_apb.pwdata;
					if (i_apb.paddr[7:5] == OFF_THI[7:5] && i_apb.paddr[1:0] == 2'b00)
						next_st.sh_hi[i_apb.paddr[4:2]] = i_apb.pwdata;
				end
			endcase
		end
		for (int p = 0; p < NPORT; p++)
		begin
			// Pins pass two flops; the second and its one-clock delayed copy (old) feed logic
			next_st.pt[p].s1 = i_enc[p];
			next_st.pt[p].s2 = st.pt[p].s1;
			next_st.pt[p].old = st.pt[p].s2;
			// Decode counting scheme
			case (st.pt[p].setup.mode)
				IN_QUAD:
				begin
					step = (st.pt[p].s2.a ^ st.pt[p].old.a) ^ (st.pt[p].s2.b ^ st.pt[p].old.b);
					up = st.pt[p].old.a ^ st.pt[p].s2.b;
				end
				IN_PDIR:
				begin
					step = st.pt[p].s2.a && !st.pt[p].old.a;
					up = !st.pt[p].s2.b;
				end
				IN_UPDN:
				begin
					step = (st.pt[p].s2.a && !st.pt[p].old.a) ^ (st.pt[p].s2.b && !st.pt[p].old.b);
					up = st.pt[p].s2.a && !st.pt[p].old.a;
				end
				default:
				begin
					step = 1'b0;
					up = 1'b0;
				end
			endcase
			// Linear stops at the ends and flags; ring wraps
			if (step)
			begin
				if (up && st.pt[p].cnt == BCD_MAX)
				begin
					if (st.pt[p].setup.range == NR_RING)
						next_st.pt[p].cnt = 32'h0;
					else
						next_st.pt[p].ovf = 1'b1;
				end
				else if (!up && st.pt[p].cnt == 32'h0)
				begin
					if (st.pt[p].setup.range == NR_RING)
						next_st.pt[p].cnt = BCD_MAX;
					else
						next_st.pt[p].ovf = 1'b1;
				end
				else
					next_st.pt[p].cnt = bcd_step(st.pt[p].cnt, up);
			end
			// Reset methods
			rb = st.rst[RST_LSB+p];
			next_st.pt[p].swp = rb;
			zed = st.pt[p].s2.z && !st.pt[p].old.z;
			if (st.pt[p].setup.rmeth == RM_ZSW)
				clr = zed && rb;
			else if (st.pt[p].setup.rmeth == RM_SW)
				clr = rb && !st.pt[p].swp;
			else
				clr = 1'b0;
			if (clr)
			begin
				next_st.pt[p].cnt = 32'h0;
				next_st.pt[p].ovf = 1'b0;
			end
			// Commands for this port
			if (wr && i_apb.paddr == OFF_CMD && pp == 1'(p))
			begin
				case (op)
					OP_LDR_GO, OP_LDT_GO, OP_LDR, OP_LDT:
					begin
						next_st.pt[p].lo = st.sh_lo;
						next_st.pt[p].hi = st.sh_hi;
						next_st.pt[p].is_rng = (op == OP_LDR_GO) || (op == OP_LDR);
						if (op == OP_LDR_GO || op == OP_LDT_GO)
							next_st.pt[p].run = 1'b1;
					end
					OP_START: next_st.pt[p].run = 1'b1;
					OP_STOP: next_st.pt[p].run = 1'b0;
					OP_PVSET:
					begin
						next_st.pt[p].cnt = st.newpv;
						next_st.pt[p].ovf = 1'b0;
					end
					default: next_st.pt[p].run = next_st.pt[p].run;
				endcase
			end
			// Comparison; BCD orders like plain binary
			hitt = 1'b0;
			for (int i = 0; i < NENT; i++)
			begin
				nh[i] = st.pt[p].run && st.pt[p].is_rng && st.pt[p].cnt >= st.pt[p].lo[i]
					&& st.pt[p].cnt <= st.pt[p].hi[i];
				if (st.pt[p].run && !st.pt[p].is_rng && step
					&& next_st.pt[p].cnt == st.pt[p].lo[i])
					hitt = 1'b1;
			end
			next_st.pt[p].hit = nh;
			ev[p*ST_W+0] = hitt;
			ev[p*ST_W+1] = |(nh & ~st.pt[p].hit);
			ev[p*ST_W+2] = next_st.pt[p].ovf && !st.pt[p].ovf;
			// Publish once per scan
			if (st.tick)
				next_st.pt[p].pub = next_st.pt[p].cnt;
		end
		// Global mask commands
		if (wr && i_apb.paddr == OFF_CMD && op == OP_MASK)
			next_st.gmask = 1'b1;
		if (wr && i_apb.paddr == OFF_CMD && op == OP_UNMASK)
			next_st.gmask = 1'b0;
		// Read clears only bits that were returned; new events win
		if (done && !i_apb.pwrite && i_apb.paddr == OFF_ISTAT)
			next_st.istat = st.istat & ~st.prdata[2*ST_W-1:0];
		next_st.istat = next_st.istat | ev;
		next_st.irq = |(next_st.istat & next_st.imask) && !next_st.gmask;
		// One wait state, answer registered
		next_st.pready = acc;
		next_st.pslverr = acc && rbad;
		next_st.prdata = acc && !i_apb.pwrite ? rmux : 32'h0;
	end

	// State register with synchronous reset
	always_ff @(posedge i_clk)
	begin
		if (!i_rstn)
			st <= '0;
		else
			st <= next_st;
	end

	assign o_prdata = st.prdata;
	assign o_pready = st.pready;
	assign o_pslverr = st.pslverr;
	assign o_irq = st.irq;

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	a_bus_answer: assert property (acc |=> o_pready ##1 !o_pready)
		else $error("bus answer not one cycle after access");
	a_pub_stable: assert property (!st.tick |=> $stable(st.pt[0].pub))
		else $error("published count changed between scans");
	a_pub_digits: assert property (
		st.pt[0].pub[3:0] <= 4'h9 && st.pt[0].pub[31:28] <= 4'h9)
		else $error("published count not decimal");
	a_start_runs: assert property (done && i_apb.pwrite && i_apb.paddr == OFF_CMD
		&& i_apb.pwdata[3:0] == OP_START && !i_apb.pwdata[CMD_PORT] |=> st.pt[0].run)
		else $error("start did not set running");
	a_stop_halts: assert property (done && i_apb.pwrite && i_apb.paddr == OFF_CMD
		&& i_apb.pwdata[3:0] == OP_STOP && i_apb.pwdata[CMD_PORT] |=> !st.pt[1].run)
		else $error("stop did not clear running");
	a_sw_reset: assert property ($rose(st.rst[RST_LSB])
		&& st.pt[0].setup.rmeth == RM_SW && !done |=> st.pt[0].cnt == 32'h0)
		else $error("software reset did not clear count");
	a_match_run: assert property (|st.pt[0].hit
		|-> $past(st.pt[0].run && st.pt[0].is_rng))
		else $error("range flag without running range compare");
	// Mask command must drop a pending interrupt at the very next edge
	a_irq_gmask: assert property (done && i_apb.pwrite && i_apb.paddr == OFF_CMD
		&& i_apb.pwdata[3:0] == OP_MASK |=> !o_irq)
		else $error("interrupt left high after mask command");
	c_scan: cover property (st.tick ##1 st.pt[0].pub != $past(st.pt[0].pub));
	c_range: cover property (|st.pt[0].hit);
	c_irq: cover property ($rose(o_irq));
endmodule // hsc_top

// ===== testbench/enc_src.sv
// Pulse source model on the encoder pins of both ports
`timescale 1ns/1ns
module enc_src
	import hsc_pkg::*;
(
	// Clock and encoder pins
	input wire logic i_clk,
	output enc_t [NPORT-1:0] o_enc
);
	logic [1:0] ph [NPORT] = '{2'h0, 2'h0};
	initial o_enc = '0;
	// Hold three clocks so the synchroniser never sees a glitch
	task automatic hold(input int p, input logic z, b, a);
		@(posedge i_clk);
		o_enc[p] <= {z, b, a};
		repeat (2) @(posedge i_clk);
	endtask
	// One count step; one phase moves at a time, except both fall together at the end of a pulse plus direction down step
	task automatic step(input int p, input logic [3:0] m, input bit up);
		if (m == IN_QUAD)
		begin
			ph[p] = up ? ph[p] + 2'h1 : ph[p] - 2'h1;
			hold(p, 1'b0, ^ph[p], ph[p][1]);
		end
		else
		begin
			hold(p, 1'b0, m == IN_PDIR && !up, 1'b0);
			hold(p, 1'b0, !up, m == IN_PDIR || up);
			hold(p, 1'b0, 1'b0, 1'b0);
		end
	endtask
	// Index pulse, phases left where they are
	task automatic zpulse(input int p);
		hold(p, 1'b1, o_enc[p].b, o_enc[p].a);
		hold(p, 1'b0, o_enc[p].b, o_enc[p].a);
	endtask
endmodule // enc_src

// ===== testbench/test_dual_high_speed_counter_compare.sv
// Self-checking bench of the dual counter block against an integer model
`timescale 1ns/1ns
module test_dual_high_speed_counter_compare
	import hsc_pkg::*;
;
	localparam int SC = 16;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic pready, pslverr, irq, err;
	logic [31:0] prdata, rd;
	logic [31:0] lfsr = 32'hA0C9;
	apb_req_t apb = '0;
	enc_t [NPORT-1:0] enc;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int r, m;
	int cnt [NPORT] = '{0, 0};
	int ovf [NPORT] = '{0, 0};
	always #5 i_clk = ~i_clk;
	hsc_top #(.SCAN_CYCLES(SC)) dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_apb(apb),
		.o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_enc(enc), .o_irq(irq));
	enc_src src (.i_clk(i_clk), .o_enc(enc));
	// Hang guard, well above the thousand or so cycles the run needs
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			bad_count++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	function automatic logic [31:0] bcd(input int v);
		logic [31:0] b = '0;
		for (int i = 0; i < NDIG; i++)
		begin
			b[4*i +: 4] = 4'(v % 10);
			v = v / 10;
		end
		return b;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		cmp_count++;
		if (got !== want)
		begin
			bad_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// Setup, then access held until pready is seen at an edge
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge i_clk);
		apb.penable <= 1'b1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		apb <= '0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] want);
		bus(1'b0, a, 32'h0);
		chk(rd, want);
	endtask
	task automatic cmd(input op_t op, input int p);
		bus(1'b1, OFF_CMD, 32'(op) | (32'(p) << CMD_PORT));
		repeat (2) @(posedge i_clk);
	endtask
	task automatic wt();
		repeat (2 * SC + 8) @(posedge i_clk);
	endtask
	task automatic pv(input int p);
		logic [31:0] e;
		e = bcd(cnt[p]);
		rchk(p ? OFF_P2_LO : OFF_P1_LO, {16'h0, e[15:0]});
		rchk(p ? OFF_P2_HI : OFF_P1_HI, {16'h0, e[31:16]});
	endtask
	// Steps with the model following; linear clamps and flags, ring wraps
	task automatic go(input int p, input logic [3:0] md, input bit up, input int n, input bit ring);
		repeat (n)
		begin
			src.step(p, md, up);
			cnt[p] += up ? 1 : -1;
			if (cnt[p] > 99999999 || cnt[p] < 0)
			begin
				if (ring)
					cnt[p] = up ? 0 : 99999999;
				else
				begin
					cnt[p] = up ? 99999999 : 0;
					ovf[p] = 1;
				end
			end
		end
		wt();
	endtask
	initial
	begin
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		pv(0);
		pv(1);
		rchk(OFF_FLG1, 32'h0);
		$display("reset test done");
		r = int'(rnd() % 99999000);
		bus(1'b1, OFF_NEWPV, bcd(r));
		cmd(OP_PVSET, 0);
		cnt[0] = r;
		go(0, IN_QUAD, 1, int'(rnd() % 20) + 4, 0);
		go(0, IN_QUAD, 0, 3, 0);
		pv(0);
		$display("quadrature test done");
		src.zpulse(0);
		wt();
		pv(0);
		bus(1'b1, OFF_RST, 32'h2);
		rchk(OFF_RST, 32'h2);
		src.zpulse(0);
		cnt[0] = 0;
		wt();
		pv(0);
		bus(1'b1, OFF_RST, 32'h0);
		go(0, IN_QUAD, 1, 5, 0);
		bus(1'b1, OFF_SET1, 32'(RM_SW) << 4);
		src.zpulse(0);
		wt();
		pv(0);
		bus(1'b1, OFF_RST, 32'h2);
		cnt[0] = 0;
		wt();
		pv(0);
		$display("counter reset test done");
		bus(1'b1, OFF_SET2, (32'(NR_RING) << 8) | 32'(IN_PDIR));
		bus(1'b1, OFF_NEWPV, 32'h9999_9998);
		cmd(OP_PVSET, 1);
		cnt[1] = 99999998;
		go(1, IN_PDIR, 1, 3, 1);
		pv(1);
		go(1, IN_PDIR, 0, 2, 1);
		pv(1);
		bus(1'b1, OFF_SET2, 32'(IN_UPDN));
		bus(1'b1, OFF_NEWPV, 32'h2);
		cmd(OP_PVSET, 1);
		cnt[1] = 2;
		go(1, IN_UPDN, 0, 4, 0);
		pv(1);
		rchk(OFF_FLG2, 32'(ovf[1]) << FLG_OVF);
		go(1, IN_UPDN, 1, 3, 0);
		pv(1);
		$display("range and mode test done");
		bus(1'b1, OFF_NEWPV, 32'h12);
		cmd(OP_PVSET, 0);
		cnt[0] = 12;
		m = 0;
		for (int i = 0; i < NENT; i++)
		begin
			bus(1'b1, OFF_TLO + 8'(4 * i), bcd(4 * i));
			bus(1'b1, OFF_THI + 8'(4 * i), bcd(4 * i + 7));
			m |= int'(cnt[0] >= 4 * i && cnt[0] <= 4 * i + 7) << i;
		end
		bus(1'b0, OFF_ISTAT, 32'h0);
		bus(1'b1, OFF_IMASK, 32'h2);
		cmd(OP_LDR, 0);
		rchk(OFF_FLG1, 32'h0);
		cmd(OP_START, 0);
		rchk(OFF_FLG1, 32'h100 | m);
		chk({31'h0, irq}, 32'h1);
		cmd(OP_MASK, 0);
		chk({31'h0, irq}, 32'h0);
		cmd(OP_UNMASK, 0);
		chk({31'h0, irq}, 32'h1);
		rchk(OFF_ISTAT, 32'h2);
		repeat (2) @(posedge i_clk);
		chk({31'h0, irq}, 32'h0);
		cmd(OP_STOP, 0);
		bus(1'b0, OFF_FLG1, 32'h0);
		chk(rd & 32'h100, 32'h0);
		cmd(OP_LDR_GO, 0);
		rchk(OFF_FLG1, 32'h100 | m);
		cmd(OP_STOP, 0);
		cmd(OP_LDT_GO, 0);
		bus(1'b0, OFF_FLG1, 32'h0);
		chk(rd & 32'h100, 32'h100);
		// Count 12 up to 16 lands on target entry 4; range bit left from the reload
		go(0, IN_QUAD, 1, 4, 0);
		rchk(OFF_ISTAT, 32'h3);
		// Port two start and stop, overflow flag kept from the underflow
		cmd(OP_START, 1);
		rchk(OFF_FLG2, (32'(ovf[1]) << FLG_OVF) | (32'h1 << FLG_RUN));
		cmd(OP_STOP, 1);
		rchk(OFF_FLG2, 32'(ovf[1]) << FLG_OVF);
		$display("comparison test done");
		bus(1'b1, OFF_P1_LO, 32'hFFFF);
		pv(0);
		bus(1'b0, 8'h38, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		$display("bus test done");
		stop_test();
	end
endmodule // test_dual_high_speed_counter_compare
